//--- inc/poc_pkg.sv
// Constants and types for the loop operational control bank
package poc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int OFS_W  = 24;
  localparam int STEP_W = 16;
  localparam int NREF   = 4;

  localparam logic [ADDR_W-1:0] STEP_LO_ADDR = 12'h412;
  localparam logic [ADDR_W-1:0] STEP_HI_ADDR = 12'h413;
  localparam logic [ADDR_W-1:0] MODE_ADDR    = 12'ha22;
  localparam logic [ADDR_W-1:0] LRST_ADDR    = 12'ha23;
  localparam logic [ADDR_W-1:0] PHASE_ADDR   = 12'ha24;
  localparam logic [ADDR_W-1:0] OFS0_ADDR    = 12'ha28;
  localparam logic [ADDR_W-1:0] OFS1_ADDR    = 12'ha29;
  localparam logic [ADDR_W-1:0] OFS2_ADDR    = 12'ha2a;
  localparam logic [ADDR_W-1:0] CH1_ADDR     = 12'ha40;

  // Mode register fields
  localparam int MAN_LSB  = 5;
  localparam int MAN_W    = 2;
  localparam int SW_LSB   = 2;
  localparam int SW_W     = 3;
  localparam int HOLD_BIT = 1;
  localparam int FREE_BIT = 0;
  localparam logic [6:0] MODE_RST = 7'h00;
  // Loop reset register fields
  localparam int LF_BIT   = 2;
  localparam int TWH_BIT  = 1;
  localparam int ASY_BIT  = 0;
  localparam logic [2:0] LRST_RST = 3'h0;
  // Phase register fields
  localparam int PZ_BIT   = 2;
  localparam int PDN_BIT  = 1;
  localparam int PUP_BIT  = 0;
  // Second channel register fields
  localparam int SYNC_BIT = 2;
  localparam int CAL_BIT  = 1;
  localparam int PD_BIT   = 0;
  localparam logic [2:0] CH1_RST = 3'h0;
  localparam logic [STEP_W-1:0] STEP_RST = 16'h0000;

  // Switching mode encodings
  localparam logic [2:0] SW_AUTO_REV   = 3'h0;
  localparam logic [2:0] SW_AUTO_NREV  = 3'h1;
  localparam logic [2:0] SW_MAN_FB_REF = 3'h2;
  localparam logic [2:0] SW_MAN_FB_HO  = 3'h3;
  localparam logic [2:0] SW_MAN_NOFB   = 3'h4;

  typedef enum logic [2:0] {
    POC_AUTO_REV,
    POC_AUTO_NREV,
    POC_MAN_FB_REF,
    POC_MAN_FB_HO,
    POC_MAN_NOFB,
    POC_UNASSIGNED
  } poc_mode_e;
endpackage

//--- rtl/poc_edge.sv
// Registered rise and fall pulse detector for control bits
`timescale 1ns/1ns
`default_nettype none
module poc_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Level in, pulses out
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] prev_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      prev_reg <= '0;
      rise     <= '0;
      fall     <= '0;
    end else begin
      prev_reg <= level;
      rise     <= level & ~prev_reg;
      fall     <= prev_reg & ~level;
    end
  end
endmodule
`default_nettype wire

//--- rtl/poc_phase_acc.sv
// Incremental phase offset accumulator
`timescale 1ns/1ns
`default_nettype none
module poc_phase_acc
  import poc_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // One-cycle commands
  input  wire logic              zero_cmd,
  input  wire logic              down_cmd,
  input  wire logic              up_cmd,
  input  wire logic [STEP_W-1:0] step,
  // Accumulated offset, two's complement
  output logic      [OFS_W-1:0]  offset
);
  logic [OFS_W-1:0] step_ext;

  assign step_ext = {{(OFS_W-STEP_W){1'b0}}, step};

  // Zeroing wins; opposite steps in one write cancel
  always_ff @(posedge clock) begin
    if (!rstn) begin
      offset <= '0;
    end else if (zero_cmd) begin
      offset <= '0;
    end else if (down_cmd && !up_cmd) begin
      offset <= offset - step_ext;
    end else if (up_cmd && !down_cmd) begin
      offset <= offset + step_ext;
    end
  end
endmodule
`default_nettype wire

//--- rtl/poc_ctrl.sv
// Operational control register bank for both clock channels
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module poc_ctrl
  import poc_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // First loop reference selection
  output logic      [SW_W-1:0]   ref_switch_mode_field,
  output poc_mode_e              ref_switch_mode,
  output logic                   mode_auto_select,
  output logic                   mode_revertive,
  output logic                   mode_fallback_ref,
  output logic                   mode_fallback_holdover,
  output logic                   mode_unassigned,
  output logic      [MAN_W-1:0]  manual_ref_select_field,
  output logic      [NREF-1:0]   manual_ref_onehot,
  // First loop forcing
  output logic                   force_holdover,
  output logic                   force_free_run,
  // First loop resets, level while set
  output logic                   clear_loop_filter,
  output logic                   clear_tuning_history,
  output logic                   clear_auto_sync,
  // First loop phase offset
  output logic      [STEP_W-1:0] phase_step,
  output logic      [OFS_W-1:0]  phase_offset,
  output logic                   phase_update,
  // Second channel
  output logic                   chan1_dist_stall,
  output logic                   chan1_dist_restart,
  output logic                   chan1_vco_cal_start,
  output logic                   chan1_power_down
);
  logic [6:0]        mode_reg;
  logic [2:0]        lrst_reg;
  logic [2:0]        ch1_reg;
  logic [STEP_W-1:0] step_reg;
  logic [2:0]        phase_cmd_reg;
  logic [DATA_W-1:0] rdata_next;
  poc_mode_e         mode_next;
  logic              wr_mode;
  logic              wr_lrst;
  logic              wr_phase;
  logic              wr_ch1;
  logic              cal_rise;
  logic              sync_fall;
  logic [1:0]        ch1_rise;
  logic [1:0]        ch1_fall;

  // Address decode
  assign wr_mode  = wr && (addr == MODE_ADDR);
  assign wr_lrst  = wr && (addr == LRST_ADDR);
  assign wr_phase = wr && (addr == PHASE_ADDR);
  assign wr_ch1   = wr && (addr == CH1_ADDR);

  // First loop user mode register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_reg <= MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= wdata[6:0];
    end
  end

  // Loop reset register; the resets hold while the bits stay set
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lrst_reg <= LRST_RST;
    end else if (wr_lrst) begin
      lrst_reg <= wdata[2:0];
    end
  end

  // Step size, low and high bytes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      step_reg <= STEP_RST;
    end else if (wr && (addr == STEP_LO_ADDR)) begin
      step_reg[7:0] <= wdata;
    end else if (wr && (addr == STEP_HI_ADDR)) begin
      step_reg[15:8] <= wdata;
    end
  end

  // Second channel register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ch1_reg <= CH1_RST;
    end else if (wr_ch1) begin
      ch1_reg <= wdata[2:0];
    end
  end

  // Phase commands live for one cycle only
  always_ff @(posedge clock) begin
    if (!rstn) begin
      phase_cmd_reg <= 3'h0;
    end else if (wr_phase) begin
      phase_cmd_reg <= wdata[2:0];
    end else begin
      phase_cmd_reg <= 3'h0;
    end
  end

  poc_phase_acc u_acc (
    .clock    (clock),
    .rstn     (rstn),
    .zero_cmd (phase_cmd_reg[PZ_BIT]),
    .down_cmd (phase_cmd_reg[PDN_BIT]),
    .up_cmd   (phase_cmd_reg[PUP_BIT]),
    .step     (step_reg),
    .offset   (phase_offset)
  );

  always_ff @(posedge clock) begin
    if (!rstn) begin
      phase_update <= 1'b0;
    end else begin
      phase_update <= |phase_cmd_reg;
    end
  end

  assign phase_step = step_reg;

  // Edges of soft sync and calibrate bits
  poc_edge #(.W(2)) u_edge (
    .clock (clock),
    .rstn  (rstn),
    .level ({ch1_reg[SYNC_BIT], ch1_reg[CAL_BIT]}),
    .rise  (ch1_rise),
    .fall  (ch1_fall)
  );

  assign cal_rise  = ch1_rise[0];
  assign sync_fall = ch1_fall[1];

  // A sleeping VCO cannot calibrate, so the start is dropped then
  always_ff @(posedge clock) begin
    if (!rstn) begin
      chan1_vco_cal_start <= 1'b0;
    end else begin
      chan1_vco_cal_start <= cal_rise && !ch1_reg[PD_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      chan1_dist_stall   <= 1'b0;
      chan1_dist_restart <= 1'b0;
    end else begin
      chan1_dist_stall   <= ch1_reg[SYNC_BIT];
      chan1_dist_restart <= sync_fall;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      chan1_power_down <= 1'b0;
    end else begin
      chan1_power_down <= ch1_reg[PD_BIT];
    end
  end

  // Forcing and reset levels
  always_ff @(posedge clock) begin
    if (!rstn) begin
      force_holdover       <= 1'b0;
      force_free_run       <= 1'b0;
      clear_loop_filter    <= 1'b0;
      clear_tuning_history <= 1'b0;
      clear_auto_sync      <= 1'b0;
    end else begin
      force_holdover       <= mode_reg[HOLD_BIT];
      force_free_run       <= mode_reg[FREE_BIT];
      clear_loop_filter    <= lrst_reg[LF_BIT];
      clear_tuning_history <= lrst_reg[TWH_BIT];
      clear_auto_sync      <= lrst_reg[ASY_BIT];
    end
  end

  // Switching mode decode
  always_comb begin
    case (mode_reg[SW_LSB +: SW_W])
      SW_AUTO_REV:   mode_next = POC_AUTO_REV;
      SW_AUTO_NREV:  mode_next = POC_AUTO_NREV;
      SW_MAN_FB_REF: mode_next = POC_MAN_FB_REF;
      SW_MAN_FB_HO:  mode_next = POC_MAN_FB_HO;
      SW_MAN_NOFB:   mode_next = POC_MAN_NOFB;
      default:       mode_next = POC_UNASSIGNED;
    endcase
  end

  // Undefined codes are flagged and steer no selection behaviour
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ref_switch_mode        <= POC_AUTO_REV;
      ref_switch_mode_field  <= MODE_RST[SW_LSB +: SW_W];
      mode_auto_select       <= 1'b1;
      mode_revertive         <= 1'b1;
      mode_fallback_ref      <= 1'b0;
      mode_fallback_holdover <= 1'b0;
      mode_unassigned        <= 1'b0;
    end else begin
      ref_switch_mode        <= mode_next;
      ref_switch_mode_field  <= mode_reg[SW_LSB +: SW_W];
      case (mode_next)
        POC_AUTO_REV: begin
          mode_auto_select       <= 1'b1;
          mode_revertive         <= 1'b1;
          mode_fallback_ref      <= 1'b0;
          mode_fallback_holdover <= 1'b0;
          mode_unassigned        <= 1'b0;
        end
        POC_AUTO_NREV: begin
          mode_auto_select       <= 1'b1;
          mode_revertive         <= 1'b0;
          mode_fallback_ref      <= 1'b0;
          mode_fallback_holdover <= 1'b0;
          mode_unassigned        <= 1'b0;
        end
        POC_MAN_FB_REF: begin
          mode_auto_select       <= 1'b0;
          mode_revertive         <= 1'b0;
          mode_fallback_ref      <= 1'b1;
          mode_fallback_holdover <= 1'b0;
          mode_unassigned        <= 1'b0;
        end
        POC_MAN_FB_HO: begin
          mode_auto_select       <= 1'b0;
          mode_revertive         <= 1'b0;
          mode_fallback_ref      <= 1'b0;
          mode_fallback_holdover <= 1'b1;
          mode_unassigned        <= 1'b0;
        end
        POC_MAN_NOFB: begin
          mode_auto_select       <= 1'b0;
          mode_revertive         <= 1'b0;
          mode_fallback_ref      <= 1'b0;
          mode_fallback_holdover <= 1'b0;
          mode_unassigned        <= 1'b0;
        end
        default: begin
          mode_auto_select       <= 1'b0;
          mode_revertive         <= 1'b0;
          mode_fallback_ref      <= 1'b0;
          mode_fallback_holdover <= 1'b0;
          mode_unassigned        <= 1'b1;
        end
      endcase
    end
  end

  // Manual reference choice, one-hot per input
  always_ff @(posedge clock) begin
    if (!rstn) begin
      manual_ref_select_field <= MODE_RST[MAN_LSB +: MAN_W];
    end else begin
      manual_ref_select_field <= mode_reg[MAN_LSB +: MAN_W];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NREF; gi++) begin : g_ref
      always_ff @(posedge clock) begin
        if (!rstn) begin
          manual_ref_onehot[gi] <= (gi == 0);
        end else begin
          manual_ref_onehot[gi] <= (mode_reg[MAN_LSB +: MAN_W] == MAN_W'(gi));
        end
      end
    end
  endgenerate

  // Read mux; reserved and unmapped read zero
  always_comb begin
    rdata_next = 8'h00;
    case (addr)
      STEP_LO_ADDR: rdata_next = step_reg[7:0];
      STEP_HI_ADDR: rdata_next = step_reg[15:8];
      MODE_ADDR:    rdata_next = {1'b0, mode_reg};
      LRST_ADDR:    rdata_next = {5'h00, lrst_reg};
      PHASE_ADDR:   rdata_next = 8'h00;
      OFS0_ADDR:    rdata_next = phase_offset[7:0];
      OFS1_ADDR:    rdata_next = phase_offset[15:8];
      OFS2_ADDR:    rdata_next = phase_offset[23:16];
      CH1_ADDR:     rdata_next = {5'h00, ch1_reg};
      default:      rdata_next = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- test/poc_ctrl_props.sv
// Assertion checker for the operational control bank
`timescale 1ns/1ns
`default_nettype none
module poc_ctrl_props
  import poc_pkg::*;
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              rstn,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  // First loop
  input wire logic              mode_auto_select,
  input wire logic              mode_revertive,
  input wire logic              mode_unassigned,
  input wire logic [NREF-1:0]   manual_ref_onehot,
  input wire logic [STEP_W-1:0] phase_step,
  input wire logic [OFS_W-1:0]  phase_offset,
  input wire logic              phase_update,
  // Second channel
  input wire logic              chan1_dist_stall,
  input wire logic              chan1_dist_restart,
  input wire logic              chan1_vco_cal_start,
  input wire logic              chan1_power_down
);
  wire logic mode_w = wr && (addr == MODE_ADDR);
  wire logic ph_w   = wr && (addr == PHASE_ADDR);
  wire logic ch_w   = wr && (addr == CH1_ADDR);

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_phase_reads_zero: assert property ($past(rd && addr == PHASE_ADDR) |-> rdata == 8'h00)
    else $error("phase register read not zero");
  a_mode_unassigned: assert property ($past(mode_w, 2) && !$past(mode_w) |->
    mode_unassigned == ($past(wdata[4:2], 2) > 3'h4))
    else $error("unassigned mode flag wrong");
  a_auto_rev: assert property ($past(mode_w, 2) && !$past(mode_w) && $past(wdata[4:2], 2) == 3'h0 |->
    mode_auto_select && mode_revertive)
    else $error("revertive automatic mode not decoded");
  a_onehot_ref: assert property ($past(mode_w, 2) && !$past(mode_w) |->
    manual_ref_onehot == 4'h1 << $past(wdata[6:5], 2))
    else $error("manual reference one-hot wrong");
  a_step_up: assert property ($past(ph_w && wdata[2:0] == 3'h1, 2) |->
    phase_offset == $past(phase_offset) + OFS_W'($past(phase_step)))
    else $error("offset not raised by step");
  a_step_down: assert property ($past(ph_w && wdata[2:0] == 3'h2, 2) |->
    phase_offset == $past(phase_offset) - OFS_W'($past(phase_step)))
    else $error("offset not lowered by step");
  a_zero_offset: assert property ($past(ph_w && wdata[2], 2) |-> phase_offset == '0)
    else $error("offset not zeroed");
  // Pulse rises with the offset, one edge after the command register
  a_update_pulse: assert property ($past(ph_w && wdata[2:0] == 3'h1, 2) && !$past(ph_w) |->
    phase_update ##1 !phase_update)
    else $error("phase update pulse missing");
  a_ch1_levels: assert property ($past(ch_w, 2) && !$past(ch_w) |->
    chan1_dist_stall == $past(wdata[2], 2) && chan1_power_down == $past(wdata[0], 2))
    else $error("stall or power-down level wrong");
  a_cal_cause: assert property (chan1_vco_cal_start |->
    $past(ch_w && wdata[1] && !wdata[0], 3) ##1 !chan1_vco_cal_start)
    else $error("calibration start without rising write");
  a_restart_cause: assert property (chan1_dist_restart |->
    $past(ch_w && !wdata[2], 3) ##1 !chan1_dist_restart)
    else $error("restart without falling write");
endmodule

bind poc_ctrl poc_ctrl_props u_props (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .mode_auto_select(mode_auto_select), .mode_revertive(mode_revertive),
  .mode_unassigned(mode_unassigned), .manual_ref_onehot(manual_ref_onehot), .phase_step(phase_step),
  .phase_offset(phase_offset), .phase_update(phase_update), .chan1_dist_stall(chan1_dist_stall),
  .chan1_dist_restart(chan1_dist_restart), .chan1_vco_cal_start(chan1_vco_cal_start),
  .chan1_power_down(chan1_power_down));
`default_nettype wire

//--- test/poc_ctrl_bench.sv
// Self-checking bench for the operational control bank
`timescale 1ns/1ns
`default_nettype none
module poc_ctrl_bench
  import poc_pkg::*;
;
  logic              clock = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [ADDR_W-1:0] addr  = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, d;
  logic [SW_W-1:0]   ref_switch_mode_field;
  poc_mode_e         ref_switch_mode;
  logic              mode_auto_select, mode_revertive, mode_fallback_ref, mode_fallback_holdover, mode_unassigned;
  logic [MAN_W-1:0]  manual_ref_select_field;
  logic [NREF-1:0]   manual_ref_onehot;
  logic              force_holdover, force_free_run, clear_loop_filter, clear_tuning_history, clear_auto_sync;
  logic [STEP_W-1:0] phase_step, step_m;
  logic [OFS_W-1:0]  phase_offset, ofs_m;
  logic              phase_update, chan1_dist_stall, chan1_dist_restart, chan1_vco_cal_start, chan1_power_down;
  logic [3:0]        n_cal, n_rst, n_upd;
  logic [31:0]       seed = 32'h6b70;
  int                errors = 0, cmp_count = 0;
  wire logic [4:0]   flags = {mode_auto_select, mode_revertive, mode_fallback_ref, mode_fallback_holdover,
                              mode_unassigned};
  // Command tables, entry 0 in the low bits
  localparam logic [14:0] PCMD = {3'h7, 3'h4, 3'h3, 3'h2, 3'h1};
  localparam logic [55:0] CHD  = {8'h00, 8'h03, 8'h00, 8'h02, 8'h02, 8'h00, 8'hf4};
  localparam logic [6:0]  CALM = 7'b0000100;
  localparam logic [6:0]  RSTM = 7'b0000010;

  poc_ctrl DUT (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ref_switch_mode_field(ref_switch_mode_field), .ref_switch_mode(ref_switch_mode),
    .mode_auto_select(mode_auto_select), .mode_revertive(mode_revertive), .mode_fallback_ref(mode_fallback_ref),
    .mode_fallback_holdover(mode_fallback_holdover), .mode_unassigned(mode_unassigned),
    .manual_ref_select_field(manual_ref_select_field), .manual_ref_onehot(manual_ref_onehot),
    .force_holdover(force_holdover), .force_free_run(force_free_run), .clear_loop_filter(clear_loop_filter),
    .clear_tuning_history(clear_tuning_history), .clear_auto_sync(clear_auto_sync), .phase_step(phase_step),
    .phase_offset(phase_offset), .phase_update(phase_update), .chan1_dist_stall(chan1_dist_stall),
    .chan1_dist_restart(chan1_dist_restart), .chan1_vco_cal_start(chan1_vco_cal_start),
    .chan1_power_down(chan1_power_down));

  always #20 clock = ~clock;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Each access starts on a fresh edge, so a strobe never gets two values in one step
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(negedge clock);
    chk(rdata, e);
  endtask

  // The update pulse lands one edge after the write, the cal and restart pulses two; five cycles leave margin
  task automatic watch;
    n_cal = 4'h0;
    n_rst = 4'h0;
    n_upd = 4'h0;
    repeat (5) begin
      @(negedge clock);
      n_cal = n_cal + chan1_vco_cal_start;
      n_rst = n_rst + chan1_dist_restart;
      n_upd = n_upd + phase_update;
    end
  endtask

  task automatic chk_reset;
    chk(flags, 5'b11000);
    chk(ref_switch_mode, POC_AUTO_REV);
    chk(manual_ref_onehot, 4'h1);
    chk({force_holdover, force_free_run, clear_loop_filter, clear_tuning_history, clear_auto_sync}, '0);
    chk({chan1_dist_stall, chan1_power_down}, 2'b00);
    chk(phase_offset, '0);
    rd_chk(MODE_ADDR, 8'h00);
    rd_chk(LRST_ADDR, 8'h00);
    rd_chk(CH1_ADDR, 8'h00);
    rd_chk(STEP_LO_ADDR, 8'h00);
    rd_chk(12'ha25, 8'h00);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk_reset;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = {1'b1, i[1:0], i[2:0], seed[1:0]};
      wr_reg(MODE_ADDR, d);
      watch;
      chk(flags, {i < 2, i == 0, i == 2, i == 3, i > 4});
      chk(ref_switch_mode, i > 4 ? POC_UNASSIGNED : i);
      chk(manual_ref_onehot, 4'h1 << i[1:0]);
      chk(manual_ref_select_field, i[1:0]);
      chk({ref_switch_mode_field, force_holdover, force_free_run}, {i[2:0], seed[1:0]});
      rd_chk(MODE_ADDR, d & 8'h7f);
    end
    for (int j = 0; j < 3; j++) begin
      wr_reg(LRST_ADDR, 8'hf8 | (8'h1 << j));
      watch;
      chk({clear_loop_filter, clear_tuning_history, clear_auto_sync}, 3'h1 << j);
      rd_chk(LRST_ADDR, 8'h1 << j);
    end
    wr_reg(LRST_ADDR, 8'h00);
    ofs_m = '0;
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      if (k % 4 == 0) begin
        step_m = seed[31:16] | 16'h1;
        wr_reg(STEP_LO_ADDR, step_m[7:0]);
        wr_reg(STEP_HI_ADDR, step_m[15:8]);
        rd_chk(STEP_HI_ADDR, step_m[15:8]);
      end
      d = {seed[7:3], k < 5 ? PCMD[3*k +: 3] : seed[2:0]};
      wr_reg(PHASE_ADDR, d);
      watch;
      // Clear wins; up and down together cancel
      if (d[2])
        ofs_m = '0;
      else if (d[1:0] == 2'h1)
        ofs_m = ofs_m + step_m;
      else if (d[1:0] == 2'h2)
        ofs_m = ofs_m - step_m;
      chk(phase_offset, ofs_m);
      chk(phase_step, step_m);
      if (d[2:0] == 3'h1 || d[2:0] == 3'h2)
        chk(n_upd, 4'h1);
      rd_chk(PHASE_ADDR, 8'h00);
      for (int b = 0; b < 3; b++)
        rd_chk(ADDR_W'(OFS0_ADDR + b), ofs_m[8*b +: 8]);
    end
    for (int c = 0; c < 7; c++) begin
      d = CHD[8*c +: 8];
      wr_reg(CH1_ADDR, d);
      watch;
      chk({n_cal, n_rst}, {3'h0, CALM[c], 3'h0, RSTM[c]});
      chk({chan1_dist_stall, chan1_power_down}, {d[2], d[0]});
      rd_chk(CH1_ADDR, d & 8'h07);
    end
    wr_reg(12'ha25, 8'hff);
    rd_chk(12'ha25, 8'h00);
    // Mode left at an unassigned code so a missed reset shows
    @(posedge clock);
    rstn <= 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk_reset;
    end_sim;
  end

  initial begin
    #2000000;
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
